// ### rtl/rsfd_defs.svh
// Constants of the submessage flag decoder.
`ifndef RSFD_DEFS_SVH
`define RSFD_DEFS_SVH
// ****************************************************************
// Message layout
// ****************************************************************
`define RSFD_MSG_HDR_LEN 16'h0014
`define RSFD_SUB_HDR_LAST 16'h0003
`define RSFD_FRAG_BASE 16'h0004
// ****************************************************************
// Submessage identifiers
// ****************************************************************
`define RSFD_ID_PAD 8'h01
`define RSFD_ID_HEARTBEAT 8'h07
`define RSFD_ID_GAP 8'h08
`define RSFD_ID_INFO_TS 8'h09
`define RSFD_ID_INFO_SRC 8'h0c
`define RSFD_ID_INFO_REPLY_IP4 8'h0d
`define RSFD_ID_INFO_DST 8'h0e
`define RSFD_ID_INFO_REPLY 8'h0f
`define RSFD_ID_NACK_FRAG 8'h12
`define RSFD_ID_HB_FRAG 8'h13
`define RSFD_ID_DATA_FRAG 8'h16
// ****************************************************************
// Flag masks
// ****************************************************************
`define RSFD_FLAG_ENDIAN 8'h01
`define RSFD_FLAG_BIT1 8'h02
`define RSFD_FLAG_BIT2 8'h04
// ****************************************************************
// Register map
// ****************************************************************
`define RSFD_REG_CTRL 8'h00
`define RSFD_REG_COUNT 8'h04
`define RSFD_REG_LAST 8'h08
`define RSFD_CTRL_RESET 1'b1
`endif

// ### rtl/rsfd_pkg.sv
// Types shared by the submessage flag decoder.
package rsfd_pkg;
    typedef enum logic [3:0] {
        ST_MSGHDR = 4'b0001,
        ST_SUBHDR = 4'b0010,
        ST_BODY = 4'b0100,
        ST_SKIP = 4'b1000
    } rsfd_state_type;

    typedef struct packed {
        logic endian;
        logic inlineQos;
        logic key;
        logic finalFlag;
        logic liveliness;
        logic multicast;
        logic invalidate;
    } rsfd_flags_type;

    typedef struct packed {
        logic [15:0] octetsToInlineQos;
        logic [31:0] readerId;
        logic [31:0] writerId;
        logic [63:0] seqNum;
        logic [31:0] fragNum;
        logic [15:0] fragsInSub;
        logic [15:0] fragSize;
        logic [31:0] sampleSize;
        logic [63:0] timestamp;
        logic [15:0] srcVersion;
        logic [15:0] srcVendor;
    } rsfd_body_type;
endpackage

// ### rtl/rtps_submessage_flag_decoder.sv
// Submessage parser: flag decode, field capture, transmit flag masking.
// Notes on behaviour
// - DataFrag flag 0x02 marks inline QoS present.
// - DataFrag key flag is mask 0x04.
// - DataFrag key clear: sample data; set: serialized key.
// - DataFrag body: flags, offset, ids, sequence, fragment fields, QoS, payload.
// - Gap, InfoDst, InfoSrc, Pad, NackFrag: endianness flag only.
// - HeartBeatFrag: endianness flag only.
// - Gap body: reader id, writer id, gap start, gap list.
// - HeartBeat final flag is mask 0x02.
// - HeartBeat liveliness flag is mask 0x04.
// - Liveliness flag set refreshes writer manual liveliness.
// - InfoReply flag 0x02 adds multicast locators.
// - InfoReplyIp4 decodes like InfoReply; multicast mask 0x02.
// - InfoTimestamp invalidate flag is mask 0x02.
// - Invalidate clear adopts timestamp; set leaves later submessages without one.
// - Datagram end ends the message.
// - Octets-to-inline-QoS skips unknown fields.
`timescale 1ns/1ps
`include "rsfd_defs.svh"

module rtps_submessage_flag_decoder #(
    parameter int COUNT_W = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] inByte,
    input wire logic inValid,
    input wire logic inLast,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic subDone,
    output logic [7:0] subKind,
    output rsfd_pkg::rsfd_flags_type subFlags,
    output rsfd_pkg::rsfd_body_type subBody,
    output logic hbResponseNeeded,
    output logic livelinessRefresh,
    output logic tsValid,
    output logic [7:0] elemByte,
    output logic elemValid,
    input wire logic [7:0] txKind,
    input wire logic [7:0] txFlagsReq,
    output logic [7:0] txFlags
);
    if (COUNT_W < 16) begin : g_count_check
        $error("COUNT_W must hold a 16-bit submessage length");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Only the bits each kind defines survive; the rest read as zero.
    function automatic logic [7:0] flagMask(input logic [7:0] kind);
        case (kind)
            `RSFD_ID_DATA_FRAG: flagMask = `RSFD_FLAG_ENDIAN | `RSFD_FLAG_BIT1 | `RSFD_FLAG_BIT2;
            `RSFD_ID_HEARTBEAT: flagMask = `RSFD_FLAG_ENDIAN | `RSFD_FLAG_BIT1 | `RSFD_FLAG_BIT2;
            `RSFD_ID_INFO_REPLY, `RSFD_ID_INFO_REPLY_IP4,
            `RSFD_ID_INFO_TS: flagMask = `RSFD_FLAG_ENDIAN | `RSFD_FLAG_BIT1;
            default: flagMask = `RSFD_FLAG_ENDIAN;
        endcase
    endfunction

    function automatic logic [31:0] order32(input logic [31:0] w, input logic le);
        order32 = le ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction

    function automatic logic [15:0] order16(input logic [15:0] w, input logic le);
        order16 = le ? {w[7:0], w[15:8]} : w;
    endfunction

    // ****************************************************************
    // Registers and parse state
    // ****************************************************************
    rsfd_pkg::rsfd_state_type state;
    rsfd_pkg::rsfd_state_type next_state;
    logic enable;
    logic [COUNT_W-1:0] idx;
    logic [15:0] bodyLen;
    logic [7:0] rawFlags;
    logic [31:0] word;
    logic [31:0] next_word;
    logic [15:0] subCount;
    logic take;
    logic le;
    logic doneNow;
    logic [15:0] rel;
    logic [7:0] maskedFlags;
    logic [15:0] lenNow;

    assign take = inValid && enable;
    assign next_word = {word[23:0], inByte};
    assign le = rawFlags[0];
    assign maskedFlags = rawFlags & flagMask(subKind);
    assign lenNow = order16(next_word[15:0], rawFlags[0]);
    assign rel = (subKind == `RSFD_ID_DATA_FRAG) ? idx[15:0] - `RSFD_FRAG_BASE : idx[15:0];
    assign doneNow = take && !inLast && (
        (state == rsfd_pkg::ST_SUBHDR && idx[15:0] == `RSFD_SUB_HDR_LAST && lenNow == 16'h0000)
        || (state == rsfd_pkg::ST_BODY && idx[15:0] == bodyLen - 16'h0001));

    always_comb begin
        next_state = state;
        if (take && inLast) begin
            next_state = rsfd_pkg::ST_MSGHDR;
        end else if (take) begin
            case (state)
                rsfd_pkg::ST_MSGHDR: begin
                    if (idx[15:0] == `RSFD_MSG_HDR_LEN - 16'h0001) begin
                        next_state = rsfd_pkg::ST_SUBHDR;
                    end
                end
                rsfd_pkg::ST_SUBHDR: begin
                    if (idx[15:0] == `RSFD_SUB_HDR_LAST && lenNow != 16'h0000) begin
                        next_state = rsfd_pkg::ST_BODY;
                    end
                end
                rsfd_pkg::ST_BODY: begin
                    if (doneNow) begin
                        next_state = rsfd_pkg::ST_SUBHDR;
                    end
                end
                default: next_state = rsfd_pkg::ST_SKIP;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= rsfd_pkg::ST_MSGHDR;
            idx <= '0;
        end else begin
            state <= next_state;
            if (take && (inLast || doneNow || next_state != state)) begin
                idx <= '0;
            end else if (take) begin
                idx <= idx + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            word <= 32'h0;
            subKind <= 8'h00;
            rawFlags <= 8'h00;
            bodyLen <= 16'h0000;
        end else if (take) begin
            word <= next_word;
            if (state == rsfd_pkg::ST_SUBHDR && idx[15:0] == 16'h0000) begin
                subKind <= inByte;
            end
            if (state == rsfd_pkg::ST_SUBHDR && idx[15:0] == 16'h0001) begin
                rawFlags <= inByte;
            end
            if (state == rsfd_pkg::ST_SUBHDR && idx[15:0] == `RSFD_SUB_HDR_LAST) begin
                bodyLen <= lenNow;
            end
        end
    end

    // ****************************************************************
    // Field capture
    // ****************************************************************
    // Entity ids are octet arrays, so they are never byte swapped.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            subBody <= '0;
        end else if (take && state == rsfd_pkg::ST_BODY) begin
            if (subKind == `RSFD_ID_DATA_FRAG && idx[15:0] == 16'h0003) begin
                subBody.octetsToInlineQos <= order16(next_word[15:0], le);
            end
            if (subKind == `RSFD_ID_DATA_FRAG || subKind == `RSFD_ID_GAP) begin
                case (rel)
                    16'h0003: subBody.readerId <= next_word;
                    16'h0007: subBody.writerId <= next_word;
                    16'h000b: subBody.seqNum[63:32] <= order32(next_word, le);
                    16'h000f: subBody.seqNum[31:0] <= order32(next_word, le);
                    default: ;
                endcase
            end
            if (subKind == `RSFD_ID_DATA_FRAG) begin
                case (rel)
                    16'h0013: subBody.fragNum <= order32(next_word, le);
                    16'h0015: subBody.fragsInSub <= order16(next_word[15:0], le);
                    16'h0017: subBody.fragSize <= order16(next_word[15:0], le);
                    16'h001b: subBody.sampleSize <= order32(next_word, le);
                    default: ;
                endcase
            end
            if (subKind == `RSFD_ID_INFO_TS && !rawFlags[1]) begin
                case (idx[15:0])
                    16'h0003: subBody.timestamp[63:32] <= order32(next_word, le);
                    16'h0007: subBody.timestamp[31:0] <= order32(next_word, le);
                    default: ;
                endcase
            end
            if (subKind == `RSFD_ID_INFO_SRC) begin
                case (idx[15:0])
                    16'h0005: subBody.srcVersion <= next_word[15:0];
                    16'h0007: subBody.srcVendor <= next_word[15:0];
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // Element stream and submessage events
    // ****************************************************************
    // The consumer splits inline QoS from payload using subFlags.inlineQos.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            elemValid <= 1'b0;
            elemByte <= 8'h00;
        end else begin
            elemValid <= take && state == rsfd_pkg::ST_BODY && subKind == `RSFD_ID_DATA_FRAG
                && idx[15:0] >= `RSFD_FRAG_BASE + subBody.octetsToInlineQos;
            elemByte <= inByte;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            subDone <= 1'b0;
            subFlags <= '0;
            hbResponseNeeded <= 1'b0;
            livelinessRefresh <= 1'b0;
        end else begin
            subDone <= doneNow;
            hbResponseNeeded <= doneNow && subKind == `RSFD_ID_HEARTBEAT && !rawFlags[1];
            livelinessRefresh <= doneNow && subKind == `RSFD_ID_HEARTBEAT && rawFlags[2];
            if (doneNow) begin
                subFlags.endian <= maskedFlags[0];
                subFlags.inlineQos <= subKind == `RSFD_ID_DATA_FRAG && maskedFlags[1];
                subFlags.key <= subKind == `RSFD_ID_DATA_FRAG && maskedFlags[2];
                subFlags.finalFlag <= subKind == `RSFD_ID_HEARTBEAT && maskedFlags[1];
                subFlags.liveliness <= subKind == `RSFD_ID_HEARTBEAT && maskedFlags[2];
                subFlags.multicast <= (subKind == `RSFD_ID_INFO_REPLY
                    || subKind == `RSFD_ID_INFO_REPLY_IP4) && maskedFlags[1];
                subFlags.invalidate <= subKind == `RSFD_ID_INFO_TS && maskedFlags[1];
            end
        end
    end

    // A timestamp lives only within its own message, so a datagram end drops it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tsValid <= 1'b0;
        end else if (take && inLast) begin
            tsValid <= 1'b0;
        end else if (doneNow && subKind == `RSFD_ID_INFO_TS) begin
            tsValid <= !rawFlags[1];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txFlags <= 8'h00;
        end else begin
            txFlags <= txFlagsReq & flagMask(txKind);
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enable <= `RSFD_CTRL_RESET;
            subCount <= 16'h0000;
            regRdData <= 32'h0;
        end else begin
            if (regWr && regAddr == `RSFD_REG_CTRL) begin
                enable <= regWrData[0];
            end
            if (regWr && regAddr == `RSFD_REG_COUNT) begin
                subCount <= 16'h0000;
            end else if (doneNow) begin
                subCount <= subCount + 16'h0001;
            end
            case (regAddr)
                `RSFD_REG_CTRL: regRdData <= regRd ? {31'h0, enable} : 32'h0;
                `RSFD_REG_COUNT: regRdData <= regRd ? {16'h0, subCount} : 32'h0;
                `RSFD_REG_LAST: regRdData <= regRd ? {16'h0, subKind, rawFlags} : 32'h0;
                default: regRdData <= 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb_main @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_frag_flags;
        doneNow && subKind == `RSFD_ID_DATA_FRAG |=>
            subFlags.inlineQos == $past(rawFlags[1]) && subFlags.key == $past(rawFlags[2]);
    endproperty
    a_frag_flags: assert property (p_frag_flags) else $error("frag flags wrong");

    property p_plain_kinds;
        doneNow && (subKind == `RSFD_ID_GAP || subKind == `RSFD_ID_PAD
            || subKind == `RSFD_ID_HB_FRAG || subKind == `RSFD_ID_NACK_FRAG) |=>
            subFlags[5:0] == 6'h00;
    endproperty
    a_plain_kinds: assert property (p_plain_kinds) else $error("extra flag decoded");

    property p_hb_flags;
        doneNow && subKind == `RSFD_ID_HEARTBEAT |=>
            subFlags.finalFlag == !hbResponseNeeded && subFlags.liveliness == livelinessRefresh;
    endproperty
    a_hb_flags: assert property (p_hb_flags) else $error("heartbeat flags wrong");

    property p_liveliness;
        livelinessRefresh |-> subDone && subFlags.liveliness && !$past(livelinessRefresh);
    endproperty
    a_liveliness: assert property (p_liveliness) else $error("bad liveliness pulse");

    property p_multicast;
        doneNow && subKind == `RSFD_ID_INFO_REPLY_IP4 |=> subFlags.multicast == $past(rawFlags[1]);
    endproperty
    a_multicast: assert property (p_multicast) else $error("multicast flag wrong");

    property p_invalidate;
        doneNow && subKind == `RSFD_ID_INFO_TS |=> tsValid == !subFlags.invalidate;
    endproperty
    a_invalidate: assert property (p_invalidate) else $error("timestamp validity wrong");

    property p_datagram_end;
        take && inLast |=> state == rsfd_pkg::ST_MSGHDR && !tsValid && !subDone;
    endproperty
    a_datagram_end: assert property (p_datagram_end) else $error("message not ended");

    property p_tx_zero;
        txKind != `RSFD_ID_DATA_FRAG && txKind != `RSFD_ID_HEARTBEAT |=> txFlags[7:2] == 6'h00;
    endproperty
    a_tx_zero: assert property (p_tx_zero) else $error("undefined tx flag driven");

    property p_elem_skip;
        elemValid |-> $past(idx[15:0]) >= `RSFD_FRAG_BASE + subBody.octetsToInlineQos;
    endproperty
    a_elem_skip: assert property (p_elem_skip) else $error("element before offset");

    c_frag: cover property (subDone && subFlags.key);
    c_hb: cover property (hbResponseNeeded);
    c_ts: cover property (tsValid ##1 !tsValid);
endmodule // rtps_submessage_flag_decoder

// ### verification/rsfd_remote_sender.sv
// Remote participant model that streams one message per datagram into the parser.
`timescale 1ns/1ps
`include "rsfd_defs.svh"
module rsfd_remote_sender (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic slow,
    output logic [7:0] inByte = 8'h00,
    output logic inValid = 1'b0,
    output logic inLast = 1'b0
);
    logic [8:0] txq[$];
    logic [8:0] b;
    // ****************************************************************
    // Encoding helpers
    // ****************************************************************
    task automatic put(input logic [7:0] v);
        txq.push_back({1'b0, v});
    endtask
    task automatic put16(input logic [15:0] v, input logic le);
        put(le ? v[7:0] : v[15:8]);
        put(le ? v[15:8] : v[7:0]);
    endtask
    task automatic put32(input logic [31:0] v, input logic le);
        put16(le ? v[15:0] : v[31:16], le);
        put16(le ? v[31:16] : v[15:0], le);
    endtask
    task automatic sub(input logic [7:0] k, input logic [7:0] f, input logic [15:0] len);
        put(k);
        put(f);
        put16(len, f[0]);
    endtask
    task automatic hdr();
        repeat (`RSFD_MSG_HDR_LEN) put(8'($urandom()));
    endtask
    task automatic fin();
        txq.push_back({1'b1, 8'($urandom())});
    endtask
    // ****************************************************************
    // Byte driver
    // ****************************************************************
    // Idle data is inverted each cycle so a stale byte can never pass for a fresh one.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            inValid <= 1'b0;
            inLast <= 1'b0;
        end else if (txq.size() != 0 && (!slow || $urandom_range(3, 0) != 0)) begin
            b = txq.pop_front();
            inByte <= b[7:0];
            inValid <= 1'b1;
            inLast <= b[8];
        end else begin
            inByte <= ~inByte;
            inValid <= 1'b0;
            inLast <= 1'b0;
        end
    end
endmodule // rsfd_remote_sender

// ### verification/testbench.sv
// Self-checking bench for the submessage flag decoder.
`timescale 1ns/1ps
`include "rsfd_defs.svh"
module testbench;
    typedef struct {logic [7:0] k; rsfd_pkg::rsfd_flags_type f; logic hb, lv; int ts;} rsfd_exp_type;
    logic core_clk = 1'b0, rst = 1'b1, slow = 1'b0, inValid, inLast, regWr = 1'b0, regRd = 1'b0;
    logic [7:0] inByte, regAddr = 8'h00, txKind = 8'h00, txFlagsReq = 8'h00, txFlags, subKind;
    logic [31:0] regWrData = 32'h0, regRdData, rd, rid, wid, sh, sl, fn, ss, sec, frac;
    logic subDone, hbResponseNeeded, livelinessRefresh, tsValid, elemValid;
    logic [7:0] elemByte, f, pl[4];
    logic [15:0] o, fc, fs, ver, ven;
    rsfd_pkg::rsfd_flags_type subFlags;
    rsfd_pkg::rsfd_body_type subBody;
    rsfd_exp_type e, expq[$];
    logic [7:0] elemq[$];
    int errors = 0, checks_done = 0;
    logic [7:0] kinds[11] = '{`RSFD_ID_PAD, `RSFD_ID_HEARTBEAT, `RSFD_ID_GAP, `RSFD_ID_INFO_TS,
        `RSFD_ID_INFO_SRC, `RSFD_ID_INFO_REPLY_IP4, `RSFD_ID_INFO_DST, `RSFD_ID_INFO_REPLY,
        `RSFD_ID_NACK_FRAG, `RSFD_ID_HB_FRAG, `RSFD_ID_DATA_FRAG};
    always #4 core_clk = ~core_clk;
    rsfd_remote_sender snd (.core_clk(core_clk), .rst(rst), .slow(slow), .inByte(inByte),
        .inValid(inValid), .inLast(inLast));
    rtps_submessage_flag_decoder dut (.core_clk(core_clk), .rst(rst), .inByte(inByte),
        .inValid(inValid), .inLast(inLast), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .subDone(subDone),
        .subKind(subKind), .subFlags(subFlags), .subBody(subBody),
        .hbResponseNeeded(hbResponseNeeded), .livelinessRefresh(livelinessRefresh),
        .tsValid(tsValid), .elemByte(elemByte), .elemValid(elemValid), .txKind(txKind),
        .txFlagsReq(txFlagsReq), .txFlags(txFlags));
    // ****************************************************************
    // Expectations and checks
    // ****************************************************************
    function automatic rsfd_pkg::rsfd_flags_type xflags(input logic [7:0] k, input logic [7:0] v);
        rsfd_pkg::rsfd_flags_type s;
        s.endian = v[0];
        s.inlineQos = k == `RSFD_ID_DATA_FRAG && v[1];
        s.key = k == `RSFD_ID_DATA_FRAG && v[2];
        s.finalFlag = k == `RSFD_ID_HEARTBEAT && v[1];
        s.liveliness = k == `RSFD_ID_HEARTBEAT && v[2];
        s.multicast = (k == `RSFD_ID_INFO_REPLY || k == `RSFD_ID_INFO_REPLY_IP4) && v[1];
        s.invalidate = k == `RSFD_ID_INFO_TS && v[1];
        return s;
    endfunction
    function automatic logic [7:0] xmask(input logic [7:0] k);
        rsfd_pkg::rsfd_flags_type s;
        s = xflags(k, 8'hff);
        return {5'h00, s.key | s.liveliness, s.inlineQos | s.finalFlag | s.multicast | s.invalidate, 1'b1};
    endfunction
    task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
        checks_done++;
        if (g !== x) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic exp_sub(input logic [7:0] k, input logic [7:0] v, input int ts);
        rsfd_exp_type x;
        x.k = k;
        x.f = xflags(k, v);
        x.hb = k == `RSFD_ID_HEARTBEAT && !v[1];
        x.lv = k == `RSFD_ID_HEARTBEAT && v[2];
        x.ts = ts;
        expq.push_back(x);
    endtask
    always @(negedge core_clk) begin
        if (elemValid === 1'b1) elemq.push_back(elemByte);
        if (subDone === 1'b1 && expq.size() == 0) chk("stray subDone", 0, 1);
        else if (subDone === 1'b1) begin
            e = expq.pop_front();
            chk("subKind", e.k, subKind);
            chk("subFlags", e.f, subFlags);
            chk("hbResponseNeeded", e.hb, hbResponseNeeded);
            chk("livelinessRefresh", e.lv, livelinessRefresh);
            if (e.ts < 2) chk("tsValid", e.ts, tsValid);
        end
    end
    // ****************************************************************
    // Bus and stream tasks
    // ****************************************************************
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic reg_rd(input logic [7:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        rd = regRdData;
        @(posedge core_clk);
    endtask
    task automatic flush();
        int n;
        n = 0;
        while ((snd.txq.size() != 0 || inValid) && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        repeat (4) @(posedge core_clk);
        chk("missing subDone", 0, expq.size());
        chk("flush time", 0, n >= 3000);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        print_verdict();
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        void'($urandom(7281));
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        reg_rd(`RSFD_REG_CTRL);
        chk("ctrl reset", 32'h1, rd);
        reg_wr(8'h40, 32'hffffffff);
        reg_rd(8'h40);
        chk("unmapped", 32'h0, rd);
        for (int p = 0; p < 2; p++) begin
            slow <= p[0];
            snd.hdr();
            foreach (kinds[i]) begin
                f = 8'($urandom());
                snd.sub(kinds[i], f, 16'h0000);
                exp_sub(kinds[i], f, 2);
            end
            for (int h = 0; h < 8; h++) begin
                snd.sub(`RSFD_ID_HEARTBEAT, 8'(h), 16'h0000);
                exp_sub(`RSFD_ID_HEARTBEAT, 8'(h), 2);
            end
            snd.fin();
            flush();
        end
        reg_rd(`RSFD_REG_COUNT);
        chk("count", 32'h26, rd);
        reg_wr(`RSFD_REG_COUNT, 32'h0);
        reg_wr(`RSFD_REG_CTRL, 32'h0);
        snd.hdr();
        snd.sub(`RSFD_ID_HEARTBEAT, 8'h00, 16'h0000);
        snd.fin();
        flush();
        reg_wr(`RSFD_REG_CTRL, 32'h1);
        reg_rd(`RSFD_REG_COUNT);
        chk("count disabled", 32'h0, rd);
        for (int le = 0; le < 2; le++) begin
            f = {5'h00, 2'($urandom()), le[0]};
            o = 16'h001c + 16'(4 * le);
            {rid, wid, sh, sl, fn, ss} = {$urandom(), $urandom(), $urandom(), $urandom(),
                $urandom(), $urandom()};
            {fc, fs} = $urandom();
            snd.hdr();
            snd.sub(`RSFD_ID_DATA_FRAG, f, o + 16'h0008);
            snd.put16(16'h0000, f[0]);
            snd.put16(o, f[0]);
            snd.put32(rid, 1'b0);
            snd.put32(wid, 1'b0);
            snd.put32(sh, f[0]);
            snd.put32(sl, f[0]);
            snd.put32(fn, f[0]);
            snd.put16(fc, f[0]);
            snd.put16(fs, f[0]);
            snd.put32(ss, f[0]);
            if (le) snd.put32($urandom(), f[0]);
            foreach (pl[i]) pl[i] = 8'($urandom());
            foreach (pl[i]) snd.put(pl[i]);
            exp_sub(`RSFD_ID_DATA_FRAG, f, 2);
            elemq.delete();
            snd.fin();
            flush();
            chk("ids", {rid, wid}, {subBody.readerId, subBody.writerId});
            chk("seqNum", {sh, sl}, subBody.seqNum);
            chk("fragNum", fn, subBody.fragNum);
            chk("frag sizes", {fc, fs, ss}, {subBody.fragsInSub, subBody.fragSize, subBody.sampleSize});
            chk("octetsToInlineQos", o, subBody.octetsToInlineQos);
            chk("elem count", 4, elemq.size());
            foreach (pl[i]) chk("elemByte", pl[i], elemq[i]);
        end
        {rid, wid, sh, sl, sec, frac} = {$urandom(), $urandom(), $urandom(), $urandom(),
            $urandom(), $urandom()};
        {ver, ven} = $urandom();
        snd.hdr();
        snd.sub(`RSFD_ID_GAP, 8'h01, 16'h001c);
        snd.put32(rid, 1'b0);
        snd.put32(wid, 1'b0);
        snd.put32(sh, 1'b1);
        snd.put32(sl, 1'b1);
        repeat (3) snd.put32($urandom(), 1'b1);
        exp_sub(`RSFD_ID_GAP, 8'h01, 0);
        snd.sub(`RSFD_ID_INFO_SRC, 8'h00, 16'h0014);
        snd.put32(32'h0, 1'b0);
        snd.put16(ver, 1'b0);
        snd.put16(ven, 1'b0);
        repeat (3) snd.put32($urandom(), 1'b0);
        exp_sub(`RSFD_ID_INFO_SRC, 8'h00, 0);
        snd.sub(`RSFD_ID_INFO_TS, 8'h01, 16'h0008);
        snd.put32(sec, 1'b1);
        snd.put32(frac, 1'b1);
        exp_sub(`RSFD_ID_INFO_TS, 8'h01, 2);
        snd.sub(`RSFD_ID_PAD, 8'h06, 16'h0000);
        exp_sub(`RSFD_ID_PAD, 8'h06, 1);
        wait (expq.size() == 0);
        chk("timestamp", {sec, frac}, subBody.timestamp);
        snd.sub(`RSFD_ID_INFO_TS, 8'h03, 16'h0000);
        exp_sub(`RSFD_ID_INFO_TS, 8'h03, 2);
        snd.sub(`RSFD_ID_PAD, 8'h00, 16'h0000);
        exp_sub(`RSFD_ID_PAD, 8'h00, 0);
        snd.fin();
        flush();
        chk("timestamp", {sec, frac}, subBody.timestamp);
        chk("gap ids", {rid, wid}, {subBody.readerId, subBody.writerId});
        chk("gapStart", {sh, sl}, subBody.seqNum);
        chk("source", {ver, ven}, {subBody.srcVersion, subBody.srcVendor});
        chk("tsValid end", 0, tsValid);
        foreach (kinds[i]) begin
            f = 8'($urandom());
            txKind <= kinds[i];
            txFlagsReq <= f;
            @(posedge core_clk);
            @(negedge core_clk);
            chk("txFlags", f & xmask(kinds[i]), txFlags);
            @(posedge core_clk);
        end
        print_verdict();
    end
endmodule // testbench
